// ===== core/aiss_sequencer.v
`timescale 1ns/1ps
`include "aiss_consts.vh"

module aiss_sequencer #(
  parameter DATA_WIDTH = 12,
  parameter POR_WAIT = `AISS_POR_WAIT,
  parameter CAL_CYCLES = `AISS_CAL_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Register port
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Converter core
  input wire [DATA_WIDTH-1:0] core_sample,
  output reg [2:0] mux_select,
  output reg [2:0] sample_channel,
  output wire correction_enable,
  // Output stream
  output reg [DATA_WIDTH-1:0] out_data,
  output reg [2:0] out_channel,
  output reg out_valid,
  // Status
  output wire calibrating,
  output wire ready
);

  localparam ST_WAIT = 3'b001;
  localparam ST_CAL = 3'b010;
  localparam ST_RUN = 3'b100;
  localparam LAT = `AISS_BASE_LATENCY;
  localparam DEPTH = `AISS_BASE_LATENCY + `AISS_POST_EXTRA;
  // Terminal counts, cut to the counter width on purpose; the
  // counters hold waits of up to 2^19 cycles
  localparam integer POR_LAST_FULL = POR_WAIT - 1;
  localparam integer CAL_LAST_FULL = CAL_CYCLES - 1;
  localparam [18:0] POR_LAST = POR_LAST_FULL[18:0];
  localparam [18:0] CAL_LAST = CAL_LAST_FULL[18:0];

  reg [2:0] state;
  reg [18:0] por_count;
  reg [18:0] cal_count;
  reg [7:0] chan_count_config;
  reg [23:0] order_word;
  reg [2:0] slot;
  // Start-up sequence next values
  reg [2:0] next_state;
  reg [18:0] next_por_count;
  reg [18:0] next_cal_count;
  // Mux select next value
  reg [2:0] next_mux_select;
  // Latency tap, chosen by the post-processing bit
  reg [DATA_WIDTH-1:0] tap_data;
  reg [2:0] tap_chan;
  reg tap_valid;
  reg [DATA_WIDTH-1:0] data_pipe [0:DEPTH-1];
  reg [2:0] chan_pipe [0:DEPTH-1];
  reg [DEPTH-1:0] valid_pipe;
  reg [2:0] next_slot;
  reg [2:0] slot_input;
  reg [2:0] last_slot;
  reg [DATA_WIDTH-1:0] coded;
  integer i;

  wire running = (state == ST_RUN);
  wire single_mode = chan_count_config[`AISS_SINGLE_BIT];
  wire post_on = chan_count_config[`AISS_POST_BIT];
  wire [2:0] nch = chan_count_config[`AISS_NCH_MSB:`AISS_NCH_LSB];

  // Per-register write strobes; unmapped offsets match none of them
  wire wr_count = reg_write && (reg_addr == `AISS_REG_CHAN_COUNT);
  wire wr_low = reg_write && (reg_addr == `AISS_REG_ORDER_LOW);
  wire wr_mid = reg_write && (reg_addr == `AISS_REG_ORDER_MID);
  wire wr_high = reg_write && (reg_addr == `AISS_REG_ORDER_HIGH);

  // Status levels straight from the one-hot state
  assign calibrating = (state == ST_CAL);
  assign ready = running;
  // Correction active from calibration onward, never stops
  assign correction_enable = (state != ST_WAIT);

  // Slot k sits in an interleaved position of the order word: the
  // first four slots climb from the low end in steps of six bits,
  // the last four climb back down between them, so slot eight sits
  // in bits 5:3 right above slot one
  function [2:0] slot_field;
    input [23:0] w;
    input [2:0] k;
    begin
      case (k)
        3'h0: slot_field = w[2:0];
        3'h1: slot_field = w[8:6];
        3'h2: slot_field = w[14:12];
        3'h3: slot_field = w[20:18];
        3'h4: slot_field = w[23:21];
        3'h5: slot_field = w[17:15];
        3'h6: slot_field = w[11:9];
        default: slot_field = w[5:3];
      endcase
    end
  endfunction

  // Next values of the start-up sequence. Both counters stop once their
  // phase is over, so a long run never wraps back into calibration;
  // the only ways back to the wait are a reset and a broken one-hot code.
  always @* begin
    next_state = state;
    next_por_count = por_count;
    next_cal_count = cal_count;
    case (state)
      ST_WAIT: begin
        // Stabilisation wait after the supply is good
        next_por_count = por_count + 19'h1;
        if (por_count == POR_LAST) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        // Calibration, with correction already on
        next_cal_count = cal_count + 19'h1;
        if (cal_count == CAL_LAST) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // Correction keeps running in the background
        next_state = ST_RUN;
      end
      default: begin
        // A broken one-hot code restarts the wait
        next_state = ST_WAIT;
        next_por_count = 19'h0;
        next_cal_count = 19'h0;
      end
    endcase
  end

  // Start-up state and counters
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_WAIT;
      por_count <= 19'h0;
      cal_count <= 19'h0;
    end else begin
      state <= next_state;
      por_count <= next_por_count;
      cal_count <= next_cal_count;
    end
  end

  // Register writes; defaults hold until the host writes. Each order
  // byte lands alone, so a half-written word can repeat an input for
  // a while; the host should scan one input while it rewrites them.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chan_count_config <= `AISS_CHAN_COUNT_DEFAULT;
      order_word <= `AISS_ORDER_DEFAULT;
    end else begin
      if (wr_count) begin
        chan_count_config <= reg_wdata;
      end
      if (wr_low) begin
        order_word[7:0] <= reg_wdata;
      end
      if (wr_mid) begin
        order_word[15:8] <= reg_wdata;
      end
      if (wr_high) begin
        order_word[23:16] <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  // Combinational, so a write shows right after the edge that takes it
  always @* begin
    case (reg_addr)
      `AISS_REG_CHAN_COUNT: reg_rdata = chan_count_config;
      `AISS_REG_ORDER_LOW: reg_rdata = order_word[7:0];
      `AISS_REG_ORDER_MID: reg_rdata = order_word[15:8];
      `AISS_REG_ORDER_HIGH: reg_rdata = order_word[23:16];
      default: reg_rdata = 8'h00;
    endcase
  end

  // Last slot index: code 000 is eight inputs, else code is count
  always @* begin
    last_slot = (nch == 3'h0) ? 3'h7 : nch - 3'h1;
    next_slot = (slot >= last_slot) ? 3'h0 : slot + 3'h1;
    slot_input = slot_field(order_word, slot);
  end

  // Mux choice for the next clock: single mode pins slot one, scan
  // mode follows the pointer; the mux is registered so the pick is
  // settled a full cycle before the sampling edge
  always @* begin
    if (single_mode) begin
      next_mux_select = slot_field(order_word, 3'h0);
    end else begin
      next_mux_select = slot_input;
    end
  end

  // Scan pointer and mux; single mode holds slot one
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slot <= 3'h0;
      mux_select <= 3'h0;
    end else begin
      mux_select <= next_mux_select;
      if (single_mode) begin
        slot <= 3'h0;
      end else begin
        slot <= next_slot;
      end
    end
  end

  // Output coding; core gives offset binary, MSB flip makes two's
  // Randomizing folds the LSB into the upper bits; the receiver undoes
  // it with the same xor, since the LSB itself passes unchanged
  always @* begin
    coded = core_sample;
    if (chan_count_config[`AISS_TWOS_BIT]) begin
      coded[DATA_WIDTH-1] = ~core_sample[DATA_WIDTH-1];
    end
    if (chan_count_config[`AISS_RAND_BIT]) begin
      coded[DATA_WIDTH-1:1] = coded[DATA_WIDTH-1:1] ^ {(DATA_WIDTH-1){coded[0]}};
    end
  end

  // Sample taken on the rising edge and pushed down the latency pipe
  // Storage is plain flip-flops; depth covers the longest tap, so the
  // short tap leaves the last stages idle when post-processing is off
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valid_pipe <= {DEPTH{1'b0}};
      sample_channel <= 3'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        data_pipe[i] <= {DATA_WIDTH{1'b0}};
        chan_pipe[i] <= 3'h0;
      end
    end else begin
      sample_channel <= mux_select;
      data_pipe[0] <= coded;
      chan_pipe[0] <= mux_select;
      valid_pipe[0] <= running;
      for (i = 1; i < DEPTH; i = i + 1) begin
        data_pipe[i] <= data_pipe[i-1];
        chan_pipe[i] <= chan_pipe[i-1];
        valid_pipe[i] <= valid_pipe[i-1];
      end
    end
  end

  // Tap at 28 stages, or four deeper with post-processing enabled.
  // The tap moves at once on a mode change, so words around the
  // switch repeat or drop; the host should discard them.
  always @* begin
    if (post_on) begin
      tap_data = data_pipe[DEPTH-1];
      tap_chan = chan_pipe[DEPTH-1];
      tap_valid = valid_pipe[DEPTH-1];
    end else begin
      tap_data = data_pipe[LAT-1];
      tap_chan = chan_pipe[LAT-1];
      tap_valid = valid_pipe[LAT-1];
    end
  end

  // Output register; its edge is the last of the latency count
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_data <= {DATA_WIDTH{1'b0}};
      out_channel <= 3'h0;
      out_valid <= 1'b0;
    end else begin
      out_data <= tap_data;
      out_channel <= tap_chan;
      out_valid <= tap_valid;
    end
  end

endmodule // aiss_sequencer

// ===== common/aiss_consts.vh
`ifndef AISS_CONSTS_VH
`define AISS_CONSTS_VH
// Register offsets
`define AISS_REG_CHAN_COUNT 8'h01
`define AISS_REG_ORDER_LOW 8'h7d
`define AISS_REG_ORDER_MID 8'h7e
`define AISS_REG_ORDER_HIGH 8'h7f
// Default scan order word (0..7), count field and control reset
`define AISS_ORDER_DEFAULT 24'h8e_ac_78
`define AISS_CHAN_COUNT_DEFAULT 8'h00
// Field positions in channel_count_config
`define AISS_NCH_LSB 0
`define AISS_NCH_MSB 2
`define AISS_SINGLE_BIT 3
`define AISS_TWOS_BIT 4
`define AISS_RAND_BIT 5
`define AISS_POST_BIT 6
// Timing
`define AISS_BASE_LATENCY 28
`define AISS_POST_EXTRA 4
`define AISS_POR_WAIT 262144
`define AISS_CAL_CYCLES 64
`endif

// ===== tb/aiss_core_model.sv
`timescale 1ns/1ps
module aiss_core_model (
  // Clock and mux in, code out
  input wire core_clk,
  input wire [2:0] mux_select,
  output reg [11:0] core_sample
);
  reg [8:0] cnt = 9'h0;
  initial core_sample = 12'h0;
  // Top bits name the input the mux shows now, so the next edge takes
  // the input and its code together and a wrong slot shows in the data
  always @(posedge core_clk) begin
    #1 cnt <= cnt + 9'h1;
    core_sample <= {mux_select, cnt};
  end
endmodule // aiss_core_model

// ===== tb/aiss_checker_assertions.sv
`timescale 1ns/1ps
module aiss_checker #(parameter POR_WAIT = 16) (
  // Clock, reset and register writes
  input wire core_clk,
  input wire reset,
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  // Sequencer outputs
  input wire [2:0] mux_select,
  input wire [2:0] sample_channel,
  input wire [2:0] out_channel,
  input wire out_valid,
  input wire calibrating,
  input wire ready,
  input wire correction_enable
);
  reg [7:0] cfg;
  reg [19:0] age;
  // Mode shadow and cycles since reset
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg <= 8'h00;
      age <= 20'h0;
    end else begin
      age <= age + 20'h1;
      if (reg_write && reg_addr == 8'h01) cfg <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  por_wait_a: assert property ($rose(calibrating) |-> age >= POR_WAIT && age <= POR_WAIT + 2) else $error("wait");
  cal_length_a: assert property ($rose(calibrating) |-> calibrating [*4] ##1 ready) else $error("cal");
  early_word_a: assert property (!ready |-> !out_valid) else $error("early");
  tag_follow_a: assert property (sample_channel == $past(mux_select)) else $error("tag");
  base_lat_a: assert property (out_valid && !cfg[6] |-> out_channel == $past(sample_channel, 28))
    else $error("lat");
  post_lat_a: assert property (out_valid && cfg[6] && $past(cfg[6], 32) |-> out_channel == $past(sample_channel, 32))
    else $error("post");
  single_hold_a: assert property (ready && cfg[3] && $past(cfg[3]) && $past(cfg[3], 2) |-> $stable(mux_select))
    else $error("single");
  corr_during_cal_a: assert property (calibrating |-> correction_enable) else $error("corr cal");
  corr_in_run_a: assert property (ready |-> correction_enable) else $error("corr run");
  scan_step_a: assert property (ready && $past(ready) && cfg[3:0] == 4'h0 && $past(cfg[3:0]) == 4'h0
    |-> !$stable(mux_select)) else $error("scan");
endmodule // aiss_checker
bind aiss_sequencer aiss_checker #(.POR_WAIT(POR_WAIT)) chk_i (.core_clk, .reset, .reg_write, .reg_addr, .reg_wdata,
  .mux_select, .sample_channel, .out_channel, .out_valid, .calibrating, .ready, .correction_enable);

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg reg_write = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  wire [11:0] core_sample, out_data;
  wire [7:0] reg_rdata;
  wire [2:0] mux_select, out_channel;
  wire out_valid, ready;
  integer error_cnt = 0, checked = 0, cycles = 0, i, k, n;
  reg [23:0] ord = 24'hfac688;
  aiss_sequencer #(.DATA_WIDTH(12), .POR_WAIT(16), .CAL_CYCLES(4)) dut (.core_clk, .reset, .reg_write, .reg_addr,
    .reg_wdata, .reg_rdata, .core_sample, .mux_select, .sample_channel(), .correction_enable(), .out_data,
    .out_channel, .out_valid, .calibrating(), .ready);
  aiss_core_model partner (.core_clk, .mux_select, .core_sample);
  // 40 ns sample clock
  always #20 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) error_cnt = error_cnt + 1;
    if (cycles == 2000) tally_and_finish;
  end
  task chk(input [11:0] got, input [11:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) error_cnt = error_cnt + 1;
      if (got !== exp) $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk) #1 {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
      @(posedge core_clk) #1 reg_write = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge core_clk) #1 reg_addr = a;
      #1 chk(reg_rdata, exp);
    end
  endtask
  // Pipe is up to 32 deep, so let it refill; then follow len slots of ord
  task scan(input integer len);
    begin
      repeat (40) @(posedge core_clk);
      #2 k = 0;
      for (i = 0; i < 8; i = i + 1) if (ord[3 * i +: 3] === out_channel) k = i;
      for (i = 0; i < (len > 0 ? 12 : 0); i = i + 1) begin
        chk(out_channel, ord[3 * ((k + i) % len) +: 3]);
        chk(out_data[11:9], ord[3 * ((k + i) % len) +: 3]);
        @(posedge core_clk) #2;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    rd(8'h7d, 8'h78);
    rd(8'h7f, 8'h8e);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    $display("register defaults done");
    while (ready !== 1'b1) @(posedge core_clk);
    scan(8);
    // One channel while the order word is half written, so no slot repeats mid-scan
    wr(8'h01, 8'h01);
    ord = 24'h0f19d5;
    wr(8'h7d, 8'h85);
    wr(8'h7e, 8'h76);
    wr(8'h7f, 8'h33);
    rd(8'h7e, 8'h76);
    for (n = 1; n <= 8; n = n + 1) begin
      wr(8'h01, {5'h0, n[2:0]});
      scan(n);
    end
    $display("scan counts done");
    wr(8'h01, 8'h08);
    scan(1);
    chk(out_data[11:9], 3'h5);
    wr(8'h01, 8'h18);
    scan(0);
    chk(out_data[11:9], 3'h1);
    wr(8'h01, 8'h28);
    scan(0);
    chk(out_data[11:9], 3'h5 ^ {3{out_data[0]}});
    wr(8'h01, 8'h48);
    scan(0);
    chk(out_valid, 1'b1);
    $display("coding and post chain done");
    tally_and_finish;
  end
endmodule // tb
